// File: include/ctb_regs.vh
`ifndef CTB_REGS_VH
`define CTB_REGS_VH

// Register byte offsets on the AXI4-Lite slave
`define CTB_ADDR_CMD        8'h00
`define CTB_ADDR_STAT       8'h04
`define CTB_ADDR_RSEL       8'h08
`define CTB_ADDR_RDATA      8'h0C
`define CTB_ADDR_SP         8'h10
`define CTB_ADDR_FLAGS      8'h14

// Command word fields
`define CTB_CMD_OP          4:0
`define CTB_CMD_RD          12:8
`define CTB_CMD_BIT         18:16
`define CTB_CMD_IO          29:24

// Status word fields
`define CTB_STAT_BUSY       0
`define CTB_STAT_FLAGS      15:8

// Processor flags register bit positions
`define CTB_FLG_C           0
`define CTB_FLG_Z           1
`define CTB_FLG_N           2
`define CTB_FLG_V           3
`define CTB_FLG_S           4
`define CTB_FLG_H           5
`define CTB_FLG_T           6
`define CTB_FLG_I           7

// Operation codes
`define CTB_OP_NOP          5'h00
`define CTB_OP_IN           5'h01
`define CTB_OP_OUT          5'h02
`define CTB_OP_PUSH         5'h03
`define CTB_OP_POP          5'h04
`define CTB_OP_EXCH         5'h05
`define CTB_OP_LSET         5'h06
`define CTB_OP_LCLR         5'h07
`define CTB_OP_LTGL         5'h08
`define CTB_OP_SHL          5'h09
`define CTB_OP_SHR          5'h0A
`define CTB_OP_ROTL         5'h0B
`define CTB_OP_ROTR         5'h0C
`define CTB_OP_SHRA         5'h0D
`define CTB_OP_SWAP         5'h0E
`define CTB_OP_IOSET        5'h0F
`define CTB_OP_IOCLR        5'h10
`define CTB_OP_B2F          5'h11
`define CTB_OP_F2B          5'h12
`define CTB_OP_FSET         5'h13
`define CTB_OP_FCLR         5'h14
`define CTB_OP_BRK          5'h15
`define CTB_OP_SLEEP        5'h16
`define CTB_OP_WDOG         5'h17

// Cycle counts, internal memory
`define CTB_CYC_ONE         2'd1
`define CTB_CYC_POP         2'd2
`define CTB_CYC_RMW         2'd2
`define CTB_CYC_SRAM_EXTRA  2'd1

// Responses and reset values
`define CTB_RESP_OKAY       2'b00
`define CTB_RESP_SLVERR     2'b10
`define CTB_SP_RST          16'h0000
`define CTB_FLAGS_RST       8'h00

`endif

// File: src/ctb_shift.v
`include "ctb_regs.vh"
`default_nettype none

// Shift and rotate unit with flag results
module ctb_shift (
  // Operation select and operand
  input  wire [4:0] op,
  input  wire [7:0] val,
  input  wire       cin,
  // Result and flags
  output reg  [7:0] res,
  output reg        c_out,
  output wire       z_out,
  output wire       n_out,
  output wire       v_out,
  output wire       s_out,
  output reg        h_out
);

  // Result, carry and half carry per operation
  always @* begin
    res   = val;
    c_out = cin;
    h_out = 1'b0;
    case (op)
      `CTB_OP_SHL: begin
        res   = {val[6:0], 1'b0};
        c_out = val[7];
        h_out = val[3];
      end
      `CTB_OP_SHR: begin
        res   = {1'b0, val[7:1]};
        c_out = val[0];
      end
      `CTB_OP_ROTL: begin
        res   = {val[6:0], cin};
        c_out = val[7];
        h_out = val[3];
      end
      `CTB_OP_ROTR: begin
        res   = {cin, val[7:1]};
        c_out = val[0];
      end
      `CTB_OP_SHRA: begin
        res   = {val[7], val[7:1]};
        c_out = val[0];
      end
      default: begin
        res   = val;
        c_out = cin;
      end
    endcase
  end

  // Common flags; overflow is N xor C after any shift
  assign z_out = (res == 8'h00);
  assign n_out = res[7];
  assign v_out = n_out ^ c_out;
  assign s_out = n_out ^ v_out;

endmodule
`default_nettype wire

// File: src/ctb_rmw.v
`include "ctb_regs.vh"
`default_nettype none

// Write-back value for the atomic memory operations
module ctb_rmw (
  // Operation and operands
  input  wire [4:0] op,
  input  wire [7:0] reg_val,
  input  wire [7:0] mem_val,
  // Value written back to memory
  output reg  [7:0] wb_val
);

  // Old register value combined with old memory byte
  always @* begin
    case (op)
      `CTB_OP_EXCH: wb_val = reg_val;
      `CTB_OP_LSET: wb_val = reg_val | mem_val;
      `CTB_OP_LCLR: wb_val = ~reg_val & mem_val;
      `CTB_OP_LTGL: wb_val = reg_val ^ mem_val;
      default:      wb_val = mem_val;
    endcase
  end

endmodule
`default_nettype wire

// File: src/ctb_core.v
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`include "ctb_regs.vh"
`default_nettype none

module ctb_core (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        rst,
  // AXI4-Lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Data memory
  output reg  [15:0] dm_addr,
  output wire        dm_re,
  output wire        dm_we,
  output reg  [7:0]  dm_wdata,
  input  wire [7:0]  dm_rdata,
  input  wire        dm_ext,
  input  wire        dm_ready,
  // I/O register space
  output wire [5:0]  io_addr,
  output wire        io_re,
  output wire        io_we,
  output reg  [7:0]  io_wdata,
  input  wire [7:0]  io_rdata,
  // Control events and levels
  output wire        brk_pulse,
  output wire        sleep_pulse,
  output wire        wdog_pulse,
  output wire        irq_enable
);

  localparam S_IDLE = 1'b0;
  localparam S_RUN  = 1'b1;

  // Architectural and bus state
  reg        state_ff;
  reg [1:0]  cnt_ff;
  reg [31:0] cmd_ff;
  reg [7:0]  rf_ff [0:31];
  reg [15:0] sp_ff;
  reg [7:0]  flags_ff;
  reg [4:0]  rsel_ff;
  reg        aw_ok_ff;
  reg        w_ok_ff;
  reg [7:0]  awaddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0]  wstrb_ff;
  integer    i;

  // Command decode
  wire [4:0] op      = cmd_ff[`CTB_CMD_OP];
  wire [4:0] rd_idx  = cmd_ff[`CTB_CMD_RD];
  wire [2:0] bit_sel = cmd_ff[`CTB_CMD_BIT];
  wire [7:0] rd_val  = rf_ff[rd_idx];
  wire [7:0] bmask   = 8'h01 << bit_sel;
  wire [15:0] zptr   = {rf_ff[31], rf_ff[30]};
  wire run       = (state_ff == S_RUN);
  wire is_push   = (op == `CTB_OP_PUSH);
  wire is_pop    = (op == `CTB_OP_POP);
  wire is_rmw    = (op == `CTB_OP_EXCH) | (op == `CTB_OP_LSET) |
                   (op == `CTB_OP_LCLR) | (op == `CTB_OP_LTGL);
  wire is_shift  = (op == `CTB_OP_SHL) | (op == `CTB_OP_SHR) |
                   (op == `CTB_OP_ROTL) | (op == `CTB_OP_ROTR) |
                   (op == `CTB_OP_SHRA);
  wire is_ioset  = (op == `CTB_OP_IOSET);
  wire is_ioclr  = (op == `CTB_OP_IOCLR);
  wire mem_rd_op = is_pop | is_rmw;
  wire mem_op    = is_push | mem_rd_op;

  // Cycles needed; reads of internal RAM pay one extra
  reg [1:0] need;
  always @* begin
    need = `CTB_CYC_ONE;
    if (is_push) begin
      need = `CTB_CYC_ONE;
    end else if (is_pop) begin
      need = `CTB_CYC_POP;
    end else if (is_rmw) begin
      need = `CTB_CYC_RMW;
    end
    if (mem_rd_op && !dm_ext) begin
      need = need + `CTB_CYC_SRAM_EXTRA;
    end
  end

  // External accesses hold the last cycle until the memory is ready
  wire last = (cnt_ff == need - `CTB_CYC_ONE);
  wire done = run && last && (!mem_op || !dm_ext || dm_ready);

  // Shift unit and atomic write-back unit
  wire [7:0] sh_res;
  wire       sh_c;
  wire       sh_z;
  wire       sh_n;
  wire       sh_v;
  wire       sh_s;
  wire       sh_h;
  wire [7:0] rmw_wb;

  ctb_shift u_shift (
    .op    (op),
    .val   (rd_val),
    .cin   (flags_ff[`CTB_FLG_C]),
    .res   (sh_res),
    .c_out (sh_c),
    .z_out (sh_z),
    .n_out (sh_n),
    .v_out (sh_v),
    .s_out (sh_s),
    .h_out (sh_h)
  );

  ctb_rmw u_rmw (
    .op      (op),
    .reg_val (rd_val),
    .mem_val (dm_rdata),
    .wb_val  (rmw_wb)
  );

  // Data memory port; read held for the whole op, write in last cycle
  assign dm_re = run && mem_rd_op;
  assign dm_we = done && (is_push || is_rmw);
  always @* begin
    if (is_push) begin
      dm_addr  = sp_ff;
      dm_wdata = rd_val;
    end else if (is_pop) begin
      dm_addr  = sp_ff + 16'h0001;
      dm_wdata = 8'h00;
    end else begin
      dm_addr  = zptr;
      dm_wdata = rmw_wb;
    end
  end

  // I/O port; bit set and clear read and write in the same cycle
  assign io_addr = cmd_ff[`CTB_CMD_IO];
  assign io_re   = run && ((op == `CTB_OP_IN) || is_ioset || is_ioclr);
  assign io_we   = run && ((op == `CTB_OP_OUT) || is_ioset || is_ioclr);
  always @* begin
    if (is_ioset) begin
      io_wdata = io_rdata | bmask;
    end else if (is_ioclr) begin
      io_wdata = io_rdata & ~bmask;
    end else begin
      io_wdata = rd_val;
    end
  end

  // Control events are single-cycle pulses
  assign brk_pulse   = done && (op == `CTB_OP_BRK);
  assign sleep_pulse = done && (op == `CTB_OP_SLEEP);
  assign wdog_pulse  = done && (op == `CTB_OP_WDOG);
  assign irq_enable  = flags_ff[`CTB_FLG_I];

  // AXI write channel acceptance, each side independent
  wire wr_fire = aw_ok_ff && w_ok_ff && !s_axi_bvalid;
  assign s_axi_awready = !aw_ok_ff;
  assign s_axi_wready  = !w_ok_ff;
  assign s_axi_arready = !s_axi_rvalid;

  wire [31:0] wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}},
                       {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  wire [31:0] wval  = wdata_ff & wmask;
  wire wr_map = (awaddr_ff == `CTB_ADDR_CMD)   || (awaddr_ff == `CTB_ADDR_STAT) ||
                (awaddr_ff == `CTB_ADDR_RSEL)  || (awaddr_ff == `CTB_ADDR_RDATA) ||
                (awaddr_ff == `CTB_ADDR_SP)    || (awaddr_ff == `CTB_ADDR_FLAGS);
  // Software changes command, registers, SP and flags only while the core is idle; RSEL writes are taken at any time
  wire sw_ok  = wr_fire && !run;

  // Write address and data capture, response
  always @(posedge sys_clk) begin
    if (rst) begin
      aw_ok_ff     <= 1'b0;
      w_ok_ff      <= 1'b0;
      awaddr_ff    <= 8'h00;
      wdata_ff     <= 32'h0000_0000;
      wstrb_ff     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `CTB_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_ok_ff) begin
        aw_ok_ff  <= 1'b1;
        awaddr_ff <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && !w_ok_ff) begin
        w_ok_ff  <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_ok_ff     <= 1'b0;
        w_ok_ff      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? `CTB_RESP_OKAY : `CTB_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read data mux
  reg [31:0] rd_mux;
  reg        rd_hit;
  wire [7:0] ar_word = {s_axi_araddr[7:2], 2'b00};
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (ar_word)
      `CTB_ADDR_CMD: rd_mux = cmd_ff;
      `CTB_ADDR_STAT: begin
        rd_mux[`CTB_STAT_BUSY]  = run;
        rd_mux[`CTB_STAT_FLAGS] = flags_ff;
      end
      `CTB_ADDR_RSEL:  rd_mux[4:0]  = rsel_ff;
      `CTB_ADDR_RDATA: rd_mux[7:0]  = rf_ff[rsel_ff];
      `CTB_ADDR_SP:    rd_mux[15:0] = sp_ff;
      `CTB_ADDR_FLAGS: rd_mux[7:0]  = flags_ff;
      default:         rd_hit = 1'b0;
    endcase
  end

  // Read response one cycle after the address is taken
  always @(posedge sys_clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `CTB_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_hit ? `CTB_RESP_OKAY : `CTB_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Sequencer: a command write starts an op, done returns to idle
  always @(posedge sys_clk) begin
    if (rst) begin
      state_ff <= S_IDLE;
      cnt_ff   <= 2'd0;
      cmd_ff   <= 32'h0000_0000;
    end else begin
      case (state_ff)
        S_IDLE: begin
          cnt_ff <= 2'd0;
          if (sw_ok && awaddr_ff == `CTB_ADDR_CMD) begin
            cmd_ff   <= wval;
            state_ff <= S_RUN;
          end
        end
        S_RUN: begin
          if (done) begin
            state_ff <= S_IDLE;
            cnt_ff   <= 2'd0;
          end else if (!last) begin
            cnt_ff <= cnt_ff + 2'd1;
          end
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  // Register file, stack pointer and flags update
  always @(posedge sys_clk) begin
    if (rst) begin
      for (i = 0; i < 32; i = i + 1) begin
        rf_ff[i] <= 8'h00;
      end
      sp_ff    <= `CTB_SP_RST;
      flags_ff <= `CTB_FLAGS_RST;
      rsel_ff  <= 5'd0;
    end else begin
      if (wr_fire && awaddr_ff == `CTB_ADDR_RSEL) begin
        rsel_ff <= wval[4:0];
      end
      if (sw_ok && awaddr_ff == `CTB_ADDR_RDATA && wstrb_ff[0]) begin
        rf_ff[rsel_ff] <= wval[7:0];
      end
      if (sw_ok && awaddr_ff == `CTB_ADDR_SP) begin
        sp_ff <= (sp_ff & ~wmask[15:0]) | wval[15:0];
      end
      if (sw_ok && awaddr_ff == `CTB_ADDR_FLAGS && wstrb_ff[0]) begin
        flags_ff <= wval[7:0];
      end
      if (done) begin
        case (op)
          `CTB_OP_IN:   rf_ff[rd_idx] <= io_rdata;
          `CTB_OP_PUSH: sp_ff <= sp_ff - 16'h0001;
          `CTB_OP_POP: begin
            rf_ff[rd_idx] <= dm_rdata;
            sp_ff         <= sp_ff + 16'h0001;
          end
          `CTB_OP_EXCH, `CTB_OP_LSET, `CTB_OP_LCLR, `CTB_OP_LTGL: begin
            rf_ff[rd_idx] <= dm_rdata;
          end
          `CTB_OP_SWAP: rf_ff[rd_idx] <= {rd_val[3:0], rd_val[7:4]};
          `CTB_OP_B2F:  flags_ff[`CTB_FLG_T] <= rd_val[bit_sel];
          `CTB_OP_F2B: begin
            rf_ff[rd_idx] <= (rd_val & ~bmask) |
                             ({8{flags_ff[`CTB_FLG_T]}} & bmask);
          end
          // Selected flag only; bit field picks I, S, V, H and the rest
          `CTB_OP_FSET: flags_ff[bit_sel] <= 1'b1;
          `CTB_OP_FCLR: flags_ff[bit_sel] <= 1'b0;
          default: begin
            if (is_shift) begin
              rf_ff[rd_idx]        <= sh_res;
              flags_ff[`CTB_FLG_C] <= sh_c;
              flags_ff[`CTB_FLG_Z] <= sh_z;
              flags_ff[`CTB_FLG_N] <= sh_n;
              flags_ff[`CTB_FLG_V] <= sh_v;
              flags_ff[`CTB_FLG_S] <= sh_s;
              // Half carry changes only for left shifts and rotates
              if (op == `CTB_OP_SHL || op == `CTB_OP_ROTL) begin
                flags_ff[`CTB_FLG_H] <= sh_h;
              end
            end
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// File: testbench/ctb_core_chk.sv
`default_nettype none
module ctb_core_chk (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rst,
  // Data memory side
  input wire logic       dm_re,
  input wire logic       dm_we,
  input wire logic       dm_ext,
  input wire logic       dm_ready,
  // I/O side
  input wire logic       io_re,
  input wire logic       io_we,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  // Control events
  input wire logic       brk_pulse,
  input wire logic       sleep_pulse,
  input wire logic       wdog_pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // I/O write strobe lasts one cycle, with no read after it
  property p_io_pulse;
    io_we |=> !io_we && !io_re;
  endproperty
  a_io_pulse: assert property (p_io_pulse)
    else $error("io write strobe longer than one cycle");
  // Bit set or clear touches one bit only
  property p_io_bit;
    io_we && io_re |-> $countones(io_wdata ^ io_rdata) <= 1;
  endproperty
  a_io_bit: assert property (p_io_bit)
    else $error("io bit op changed more than one bit");
  // Internal RAM read costs one extra cycle
  property p_int_len;
    $rose(dm_re) && !dm_ext |-> dm_re [*3] ##1 !dm_re;
  endproperty
  a_int_len: assert property (p_int_len)
    else $error("internal memory op length wrong");
  // Write-back lands in the last read cycle
  property p_we_last;
    dm_we && dm_re |=> !dm_re;
  endproperty
  a_we_last: assert property (p_we_last)
    else $error("atomic write not in last cycle");
  // External access ends on ready
  property p_ext_done;
    dm_re && $past(dm_re) && dm_ext && dm_ready |=> !dm_re;
  endproperty
  a_ext_done: assert property (p_ext_done)
    else $error("external access kept going after ready");
  // External access stretches while not ready
  property p_ext_wait;
    dm_re && $past(dm_re) && dm_ext && !dm_ready |=> dm_re;
  endproperty
  a_ext_wait: assert property (p_ext_wait)
    else $error("external access dropped before ready");
  // Push writes once, with no read
  property p_push;
    dm_we && !dm_re |-> !$past(dm_re) ##1 !dm_we;
  endproperty
  a_push: assert property (p_push)
    else $error("push longer than one cycle");
  // Control ops stand alone for one cycle
  property p_ctl_one;
    brk_pulse || sleep_pulse || wdog_pulse |-> !dm_re && !io_re && !io_we
      ##1 !(brk_pulse || sleep_pulse || wdog_pulse);
  endproperty
  a_ctl_one: assert property (p_ctl_one)
    else $error("control op pulse wrong");
endmodule
`default_nettype wire

// File: testbench/ctb_mem_model.sv
`default_nettype none
module ctb_mem_model (
  // Clock and bench control
  input  wire logic        sys_clk,
  input  wire logic        slow,
  // Data memory side
  input  wire logic [15:0] dm_addr,
  input  wire logic        dm_re,
  input  wire logic        dm_we,
  input  wire logic [7:0]  dm_wdata,
  output logic      [7:0]  dm_rdata,
  output logic             dm_ext,
  output logic             dm_ready,
  // I/O side
  input  wire logic [5:0]  io_addr,
  input  wire logic        io_re,
  input  wire logic        io_we,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:255];
  logic [7:0] io_mem [0:63];
  logic [3:0] cnt = 4'h0;
  // Idle lines churn so a stale byte never passes for an answer
  assign dm_rdata = dm_re ? mem[dm_addr[7:0]] : {cnt, ~cnt};
  assign io_rdata = io_re ? io_mem[io_addr] : {~cnt, cnt};
  // Slow mode routes to external memory, ready every fourth cycle
  assign dm_ext   = slow;
  assign dm_ready = slow ? &cnt[1:0] : cnt[0];
  // Writes land at the strobe edge
  always @(posedge sys_clk) begin
    cnt <= cnt + 4'h1;
    if (dm_we) mem[dm_addr[7:0]] <= dm_wdata;
    if (io_we) io_mem[io_addr] <= io_wdata;
  end
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
`include "ctb_regs.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk, rst, slow, co;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, dm_wdata, dm_rdata, io_wdata, io_rdata, e, x, f;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [3:0]  s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [1:0]  s_axi_bresp, s_axi_rresp, last_resp;
  logic [15:0] dm_addr;
  logic [5:0]  io_addr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, dm_re, dm_we, dm_ext;
  logic dm_ready, io_re, io_we, brk_pulse, sleep_pulse, wdog_pulse, irq_enable;
  int   failures = 0, checks_done = 0, cyc = 0, pulses = 0, p0;
  logic [4:0]  sh_ops [6] = '{`CTB_OP_SHL, `CTB_OP_SHR, `CTB_OP_ROTL, `CTB_OP_ROTR,
                              `CTB_OP_SHRA, `CTB_OP_SWAP};
  logic [4:0]  ctl_ops [4] = '{`CTB_OP_BRK, `CTB_OP_NOP, `CTB_OP_SLEEP, `CTB_OP_WDOG};
  ctb_core ctb_core_inst (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .dm_addr,
    .dm_re, .dm_we, .dm_wdata, .dm_rdata, .dm_ext, .dm_ready, .io_addr, .io_re, .io_we,
    .io_wdata, .io_rdata, .brk_pulse, .sleep_pulse, .wdog_pulse, .irq_enable);
  ctb_mem_model ctb_mem_model_inst (.sys_clk, .slow, .dm_addr, .dm_re, .dm_we, .dm_wdata,
    .dm_rdata, .dm_ext, .dm_ready, .io_addr, .io_re, .io_we, .io_wdata, .io_rdata);
  always #5 sys_clk = ~sys_clk;
  // Pulse count and hang limit
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (brk_pulse || sleep_pulse || wdog_pulse) pulses <= pulses + 1;
    if (cyc == 20000) begin
      failures++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Address and data offered together, each dropped once taken
  // Waits have no local limit; the cycle ceiling ends a hung run
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    last_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    last_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Launch an op and poll until the core is idle
  task automatic run(input logic [4:0] op, input logic [4:0] r, input logic [2:0] b,
                     input logic [5:0] io);
    axi_wr(`CTB_ADDR_CMD, {2'h0, io, 5'h00, b, 3'h0, r, 3'h0, op});
    do begin
      axi_rd(`CTB_ADDR_STAT);
    end while (v[`CTB_STAT_BUSY] !== 1'b0);
  endtask
  task automatic setr(input logic [4:0] i, input logic [7:0] d);
    axi_wr(`CTB_ADDR_RSEL, {27'h000_0000, i});
    axi_wr(`CTB_ADDR_RDATA, {24'h00_0000, d});
  endtask
  task automatic getr(input logic [4:0] i);
    axi_wr(`CTB_ADDR_RSEL, {27'h000_0000, i});
    axi_rd(`CTB_ADDR_RDATA);
  endtask
  initial begin
    {sys_clk, slow, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot} = '0;
    s_axi_wstrb = 4'hF;
    rst = 1'b1;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    // Reset value of SP, then an unmapped word both ways
    axi_rd(`CTB_ADDR_SP);
    chk(v, 32'h0000_0000);
    axi_rd(8'h40);
    chk(last_resp, `CTB_RESP_SLVERR);
    axi_wr(8'h40, 32'h0000_0001);
    chk(last_resp, `CTB_RESP_SLVERR);
    // I/O copies and single-bit edits, flags left alone
    setr(5'h03, 8'h5A);
    axi_wr(`CTB_ADDR_FLAGS, 32'h0000_002A);
    run(`CTB_OP_OUT, 5'h03, 3'h0, 6'h05);
    chk(ctb_mem_model_inst.io_mem[5], 8'h5A);
    run(`CTB_OP_IOSET, 5'h00, 3'h7, 6'h05);
    chk(ctb_mem_model_inst.io_mem[5], 8'hDA);
    run(`CTB_OP_IOCLR, 5'h00, 3'h1, 6'h05);
    chk(ctb_mem_model_inst.io_mem[5], 8'hD8);
    run(`CTB_OP_IN, 5'h04, 3'h0, 6'h05);
    getr(5'h04);
    chk(v, 32'h0000_00D8);
    // Stack round trip
    axi_wr(`CTB_ADDR_SP, 32'h0000_0040);
    run(`CTB_OP_PUSH, 5'h03, 3'h0, 6'h00);
    chk(ctb_mem_model_inst.mem[8'h40], 8'h5A);
    run(`CTB_OP_POP, 5'h06, 3'h0, 6'h00);
    getr(5'h06);
    chk(v, 32'h0000_005A);
    axi_rd(`CTB_ADDR_SP);
    chk(v, 32'h0000_0040);
    axi_rd(`CTB_ADDR_FLAGS);
    chk(v, 32'h0000_002A);
    // Atomic ops at Z, alternating internal and external memory
    setr(5'h1E, 8'h80);
    setr(5'h1F, 8'h00);
    for (int i = 0; i < 4; i++) begin
      ctb_mem_model_inst.mem[8'h80] = 8'hC3;
      slow <= i[0];
      setr(5'h08, 8'h5A);
      run(`CTB_OP_EXCH + i[4:0], 5'h08, 3'h0, 6'h00);
      getr(5'h08);
      chk(v, 32'h0000_00C3);
      x = 8'h5A;
      f = 8'hC3;
      e = i == 0 ? x : i == 1 ? x | f : i == 2 ? f & ~x : x ^ f;
      chk(ctb_mem_model_inst.mem[8'h80], e);
    end
    slow <= 1'b0;
    // Shifts, rotates and nibble swap with carry preset
    x = 8'h9C;
    for (int i = 0; i < 6; i++) begin
      setr(5'h09, x);
      axi_wr(`CTB_ADDR_FLAGS, 32'h0000_0041);
      run(sh_ops[i], 5'h09, 3'h0, 6'h00);
      case (i)
        0: {co, e} = {x, 1'b0};
        1: {e, co} = {1'b0, x};
        2: {co, e} = {x, 1'b1};
        3: {e, co} = {1'b1, x};
        4: {e, co} = {x[7], x};
        default: {co, e} = {1'b1, x[3:0], x[7:4]};
      endcase
      f = 8'h41;
      if (i < 5) f[4:0] = {co, e[7] ^ co, e[7], e == 8'h00, co};
      if (i == 0 || i == 2) f[5] = x[3];
      getr(5'h09);
      chk(v, {24'h00_0000, e});
      axi_rd(`CTB_ADDR_FLAGS);
      chk(v, {24'h00_0000, f});
    end
    // Bit transfer through the transfer flag
    axi_wr(`CTB_ADDR_FLAGS, 32'h0000_0000);
    run(`CTB_OP_B2F, 5'h03, 3'h1, 6'h00);
    axi_rd(`CTB_ADDR_FLAGS);
    chk(v, 32'h0000_0040);
    setr(5'h07, 8'h00);
    run(`CTB_OP_F2B, 5'h07, 3'h4, 6'h00);
    getr(5'h07);
    chk(v, 32'h0000_0010);
    // Every flag set and cleared alone
    axi_wr(`CTB_ADDR_FLAGS, 32'h0000_0000);
    for (int b = 0; b < 8; b++) begin
      run(`CTB_OP_FSET, 5'h00, b[2:0], 6'h00);
      axi_rd(`CTB_ADDR_FLAGS);
      chk(v, 32'h1 << b);
      chk(irq_enable, b == 7);
      run(`CTB_OP_FCLR, 5'h00, b[2:0], 6'h00);
      axi_rd(`CTB_ADDR_FLAGS);
      chk(v, 32'h0000_0000);
    end
    // Control ops and a NOP keep flags; BRK, SLEEP and WDOG pulse once each
    axi_wr(`CTB_ADDR_FLAGS, 32'h0000_00A5);
    p0 = pulses;
    foreach (ctl_ops[i]) run(ctl_ops[i], 5'h00, 3'h0, 6'h00);
    axi_rd(`CTB_ADDR_FLAGS);
    chk(v, 32'h0000_00A5);
    chk(pulses - p0, 3);
    // Status word carries idle state and the kept flags
    axi_rd(`CTB_ADDR_STAT);
    chk(v, 32'h0000_A500);
    wrap_up();
  end
endmodule
bind ctb_core ctb_core_chk ctb_core_chk_inst (.sys_clk, .rst, .dm_re, .dm_we, .dm_ext,
  .dm_ready, .io_re, .io_we, .io_wdata, .io_rdata, .brk_pulse, .sleep_pulse, .wdog_pulse);
`default_nettype wire
